// *** msecc_top.sv ***
// SEC-DED check block between the memory data buffers and DRAM.
// Assumes DRAM side logic runs on ref_clk_i; no pin crossing here.
`timescale 1ns/100ps
`default_nettype none
`include "msecc_defs.svh"
module msecc_top
  import msecc_pkg::*;
#(
  parameter int FIFO_DEPTH = `MSECC_FIFO_DEPTH,
  parameter int CNT_W      = `MSECC_CNT_W
) (
  input  wire logic                      ref_clk_i,       // Clock
  input  wire logic                      sys_rst_i,       // Reset, high
  input  wire logic                      ecc_en_i,        // Check memory
  input  wire logic                      cnt_clr_i,       // Clear counts
  input  wire logic                      wr_valid_i,      // Write offered
  output logic                           wr_ready_o,      // Write taken
  input  wire logic [`MSECC_DATA_W-1:0]  wr_data_i,       // Write data
  input  wire logic [`MSECC_LANES-1:0]   wr_par_i,        // Lane parity
  input  wire logic [`MSECC_LANES-1:0]   wr_be_i,         // Byte enables
  output logic                           mem_wr_valid_o,  // Word to DRAM
  input  wire logic                      mem_wr_ready_i,  // DRAM takes
  output logic      [`MSECC_WORD_W-1:0]  mem_wr_data_o,   // Data+check
  output logic      [`MSECC_LANES-1:0]   mem_wr_be_o,     // Byte enables
  output logic                           wr_perr_o,       // Lane par bad
  output logic      [`MSECC_LANES-1:0]   wr_perr_lane_o,  // Bad lanes
  input  wire logic                      mem_rd_valid_i,  // DRAM word
  output logic                           mem_rd_ready_o,  // Word taken
  input  wire logic [`MSECC_WORD_W-1:0]  mem_rd_data_i,   // Data+check
  output logic                           rd_valid_o,      // Read ready
  input  wire logic                      rd_ready_i,      // Buffer takes
  output logic      [`MSECC_DATA_W-1:0]  rd_data_o,       // Read data
  output logic      [`MSECC_LANES-1:0]   rd_par_o,        // Lane parity
  output logic      [`MSECC_CHK_W-1:0]   rd_syn_o,        // Syndrome
  output logic                           rd_ce_o,         // Corrected
  output logic                           rd_ue_o,         // Uncorrectable
  output logic      [CNT_W-1:0]          ce_count_o,      // CE total
  output logic      [CNT_W-1:0]          ue_count_o,      // UE total
  output logic      [`MSECC_CHK_W-1:0]   err_syn_o        // Last bad syn
);
  if (CNT_W < 1 || FIFO_DEPTH < 2) begin : g_bad
    $error("msecc_top: CNT_W >= 1 and FIFO_DEPTH >= 2 required");
  end

  localparam int DW = `MSECC_DATA_W;
  localparam int CW = `MSECC_CHK_W;
  localparam int LW = `MSECC_LANE_W;
  localparam int NL = `MSECC_LANES;
  localparam int RW = $bits(msecc_rd_type);
  localparam logic [DW*CW-1:0] HMAT = `MSECC_HMATRIX;

  // Write path: lane parity check and check-byte generation

  logic [NL-1:0] w_lane_bad;
  logic [CW-1:0] w_gen;
  logic [CW-1:0] w_chk;
  logic          w_fire;

  for (genvar k = 0; k < NL; k++) begin : g_wpar
    // Even parity: data byte plus its parity bit XOR to zero
    assign w_lane_bad[k] =
      ^{wr_par_i[k], wr_data_i[k*LW +: LW]};
  end

  msecc_chk_gen u_wr_gen (
    .data_i (wr_data_i),
    .chk_o  (w_gen)
  );

  // A poisoned write XORs the parity-error code into the check byte,
  // so a later read lands on a syndrome no single bit can produce
  always_comb begin
    w_chk = `MSECC_SYN_ZERO;
    if (ecc_en_i) begin
      w_chk = w_gen;
      if (|w_lane_bad) begin
        w_chk = w_gen ^ `MSECC_SYN_PARERR;
      end
    end
  end

  assign wr_ready_o = !mem_wr_valid_o || mem_wr_ready_i;
  assign w_fire     = wr_valid_i && wr_ready_o;

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      mem_wr_valid_o <= 1'b0;
    end else if (w_fire) begin
      mem_wr_valid_o <= 1'b1;
    end else if (mem_wr_ready_i) begin
      mem_wr_valid_o <= 1'b0;
    end
  end

  // Byte enables pass through; a partial write with checking on needs
  // the request logic to merge the old bytes first
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      mem_wr_data_o  <= '0;
      mem_wr_be_o    <= '0;
      wr_perr_lane_o <= '0;
    end else if (w_fire) begin
      mem_wr_data_o  <= {w_chk, wr_data_i};
      mem_wr_be_o    <= wr_be_i;
      wr_perr_lane_o <= w_lane_bad;
    end
  end

  assign wr_perr_o = mem_wr_valid_o && (|wr_perr_lane_o);

  // Read path: syndrome, classification and correction

  logic [DW-1:0]  r_data;
  logic [CW-1:0]  r_stored;
  logic [CW-1:0]  r_gen;
  msecc_syn_type  r_syn;
  logic [DW-1:0]  r_fix;
  logic           r_chk_hit;
  msecc_err_type  r_class;
  logic           r_ce;
  logic           r_ue;
  logic [DW-1:0]  r_data_c;
  logic [NL-1:0]  r_par;
  logic           r_fire;
  msecc_rd_type   r_word;
  msecc_rd_type   o_word;

  assign r_data   = mem_rd_data_i[DW-1:0];
  assign r_stored = mem_rd_data_i[`MSECC_WORD_W-1:DW];

  msecc_chk_gen u_rd_gen (
    .data_i (r_data),
    .chk_o  (r_gen)
  );

  // Without check storage the stored byte is meaningless; force zero
  assign r_syn =
    ecc_en_i ? (r_gen ^ r_stored) : `MSECC_SYN_ZERO;

  for (genvar i = 0; i < DW; i++) begin : g_fix
    assign r_fix[i] = r_syn == HMAT[i*CW +: CW];
  end

  // A lone set bit is a failed check bit: flagged, data left alone
  assign r_chk_hit = $onehot(r_syn);

  always_comb begin
    r_class = ERR_NONE;
    if (r_syn != `MSECC_SYN_ZERO) begin
      if ((|r_fix) || r_chk_hit) begin
        r_class = ERR_CORR;
      end else begin
        r_class = ERR_UNCORR;
      end
    end
  end

  assign r_ce     = r_class == ERR_CORR;
  assign r_ue     = r_class == ERR_UNCORR;
  assign r_data_c = r_data ^ r_fix;

  // The syndrome assumes clean write parity; an uncorrectable word is poisoned on every lane
  for (genvar k = 0; k < NL; k++) begin : g_rpar
    assign r_par[k] =
      (^r_data_c[k*LW +: LW]) ^ r_ue;
  end

  always_comb begin
    r_word      = '0;
    r_word.data = r_data_c;
    r_word.par  = r_par;
    r_word.syn  = r_syn;
    r_word.ce   = r_ce;
    r_word.ue   = r_ue;
  end

  // FIFO toward the buffer; its ready stalls the DRAM read stream

  msecc_stream_if #(.W(RW)) rq_in ();
  msecc_stream_if #(.W(RW)) rq_out ();

  assign rq_in.valid    = mem_rd_valid_i;
  assign rq_in.data     = r_word;
  assign mem_rd_ready_o = rq_in.ready;
  assign r_fire         = mem_rd_valid_i && rq_in.ready;

  msecc_fifo #(
    .W     (RW),
    .DEPTH (FIFO_DEPTH)
  ) u_rd_fifo (
    .clk_i (ref_clk_i),
    .rst_i (sys_rst_i),
    .in_s  (rq_in.snk),
    .out_s (rq_out.src)
  );

  assign o_word       = rq_out.data;
  assign rq_out.ready = rd_ready_i;
  assign rd_valid_o   = rq_out.valid;
  assign rd_data_o    = o_word.data;
  assign rd_par_o     = o_word.par;
  assign rd_syn_o     = o_word.syn;
  assign rd_ce_o      = rq_out.valid && o_word.ce;
  assign rd_ue_o      = rq_out.valid && o_word.ue;

  // Error statistics, counted as words enter the FIFO

  logic [CNT_W-1:0] ce_cnt_q;
  logic [CNT_W-1:0] ue_cnt_q;
  logic [CW-1:0]    syn_log_q;

  // An event in the clearing cycle counts as one; counts saturate
  // rather than wrap so a flood of errors never reads as few
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      ce_cnt_q <= '0;
    end else if (r_fire && r_ce) begin
      if (cnt_clr_i) ce_cnt_q <= CNT_W'(1);
      else if (ce_cnt_q != '1) ce_cnt_q <= ce_cnt_q + 1'b1;
    end else if (cnt_clr_i) begin
      ce_cnt_q <= '0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      ue_cnt_q <= '0;
    end else if (r_fire && r_ue) begin
      if (cnt_clr_i) ue_cnt_q <= CNT_W'(1);
      else if (ue_cnt_q != '1) ue_cnt_q <= ue_cnt_q + 1'b1;
    end else if (cnt_clr_i) begin
      ue_cnt_q <= '0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      syn_log_q <= `MSECC_SYN_ZERO;
    end else if (r_fire && (r_ce || r_ue)) begin
      syn_log_q <= r_syn;
    end
  end

  assign ce_count_o = ce_cnt_q;
  assign ue_count_o = ue_cnt_q;
  assign err_syn_o  = syn_log_q;

  // Checks

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);

  logic [NL-1:0] o_lane_odd;
  for (genvar k = 0; k < NL; k++) begin : g_olane
    assign o_lane_odd[k] = ^{rd_par_o[k], rd_data_o[k*LW +: LW]};
  end

  sequence s_wr_stall;
    mem_wr_valid_o && !mem_wr_ready_i;
  endsequence
  sequence s_wr_poison;
    w_fire && ecc_en_i && (|w_lane_bad);
  endsequence
  sequence s_ce_take;
    r_fire && r_ce && !cnt_clr_i && ce_cnt_q != '1;
  endsequence

  property p_wr_hold;
    s_wr_stall |=> mem_wr_valid_o && $stable(mem_wr_data_o);
  endproperty
  a_wr_hold: assert property (p_wr_hold)
    else $error("write word changed while stalled");

  property p_chk_fold;
    s_wr_poison |=> mem_wr_valid_o &&
      (mem_wr_data_o[`MSECC_WORD_W-1:DW] ^ $past(w_gen))
        == `MSECC_SYN_PARERR;
  endproperty
  a_chk_fold: assert property (p_chk_fold)
    else $error("parity error not folded into check byte");

  property p_chk_clean;
    w_fire && ecc_en_i && !(|w_lane_bad) |=>
      mem_wr_data_o[`MSECC_WORD_W-1:DW] == $past(w_gen);
  endproperty
  a_chk_clean: assert property (p_chk_clean)
    else $error("clean write check byte wrong");

  property p_bypass;
    w_fire && !ecc_en_i |=>
      mem_wr_data_o[`MSECC_WORD_W-1:DW] == `MSECC_SYN_ZERO;
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("check byte not zero in bypass");

  property p_zero_syn;
    r_fire && r_syn == `MSECC_SYN_ZERO |-> !r_ce && !r_ue &&
      r_data_c == r_data;
  endproperty
  a_zero_syn: assert property (p_zero_syn)
    else $error("zero syndrome flagged or altered data");

  property p_single;
    r_fire && r_ce |-> ($countones(r_fix) + 32'(r_chk_hit)) == 1 &&
      $countones(r_syn) % 2 == 1;
  endproperty
  a_single: assert property (p_single)
    else $error("correctable error does not fix exactly one bit");

  property p_classify;
    r_fire && r_syn != `MSECC_SYN_ZERO |-> r_ce ^ r_ue;
  endproperty
  a_classify: assert property (p_classify)
    else $error("non-zero syndrome not classified once");

  property p_parerr_ue;
    r_fire && r_syn == `MSECC_SYN_PARERR |-> r_ue;
  endproperty
  a_parerr_ue: assert property (p_parerr_ue)
    else $error("parity-error syndrome not uncorrectable");

  property p_poison;
    rd_valid_o |-> (rd_ue_o ? (&o_lane_odd) : !(|o_lane_odd));
  endproperty
  a_poison: assert property (p_poison)
    else $error("returned lane parity does not match error class");

  property p_ce_count;
    s_ce_take |=> ce_cnt_q == $past(ce_cnt_q) + 1'b1;
  endproperty
  a_ce_count: assert property (p_ce_count)
    else $error("correctable count did not advance");

  property p_flags;
    !rd_valid_o |-> !rd_ce_o && !rd_ue_o;
  endproperty
  a_flags: assert property (p_flags)
    else $error("error flag without read valid");

endmodule : msecc_top
`default_nettype wire

// *** msecc_defs.svh ***
// Constants of the memory SEC-DED check block with byte parity.
// Assumes inclusion by bare name from the package and the modules.
// What this block does
// - Store 8 check bits per 64-bit word
// - Even parity per byte lane on buffer data
// - Parity kept per lane for partial writes
// - Check all lane parities, fold into check
// - Parity-error write reads back syndrome 0110 0111
// - Check bits from XOR trees over matrix
// - Read syndrome is recomputed XOR stored
// - Fixed matrix: check bit n one-hot
// - Single-error codes all of odd weight
// - Matching syndrome inverts the indicated bit
// - Other non-zero syndromes are uncorrectable
// - Uncorrectable read drives bad parity everywhere
// - Non-ECC memory bypasses generation and correction
// - Corrected data returned with correctable flag
`ifndef MSECC_DEFS_SVH
`define MSECC_DEFS_SVH
`define MSECC_DATA_W     64
`define MSECC_CHK_W      8
`define MSECC_LANES      8
`define MSECC_LANE_W     8
`define MSECC_WORD_W     72
`define MSECC_SYN_ZERO   8'h00
`define MSECC_SYN_PARERR 8'h67
`define MSECC_FIFO_DEPTH 4
`define MSECC_CNT_W      16
// Syndrome of each data bit, bit 63 first
`define MSECC_HMATRIX { \
  8'h4c, 8'h89, 8'h8a, 8'h34, 8'h64, 8'h85, 8'h51, 8'h91, \
  8'hf8, 8'h92, 8'hc8, 8'h1a, 8'h86, 8'h1f, 8'ha8, 8'hf4, \
  8'h61, 8'h25, 8'hc2, 8'h32, 8'h13, 8'h54, 8'h2a, 8'h2f, \
  8'hc1, 8'h68, 8'h8f, 8'hb0, 8'h70, 8'h07, 8'ha1, 8'h43, \
  8'hf1, 8'h83, 8'h52, 8'h0e, 8'h26, 8'hf2, 8'h31, 8'h15, \
  8'h4f, 8'h46, 8'h0b, 8'h2c, 8'he0, 8'h98, 8'h58, 8'ha2, \
  8'h94, 8'h16, 8'h38, 8'h4a, 8'h49, 8'h19, 8'h0d, 8'h29, \
  8'h45, 8'hd0, 8'ha4, 8'hc4, 8'h62, 8'h1c, 8'h8c, 8'h23}
`endif

// *** msecc_pkg.sv ***
// Types shared by the SEC-DED check block.
// Assumes msecc_defs.svh is on the include path.
`include "msecc_defs.svh"
package msecc_pkg;
  typedef logic [`MSECC_CHK_W-1:0] msecc_syn_type;
  typedef enum logic [2:0] {
    ERR_NONE   = 3'b001,
    ERR_CORR   = 3'b010,
    ERR_UNCORR = 3'b100
  } msecc_err_type;
  typedef struct packed {
    logic [`MSECC_DATA_W-1:0] data;
    logic [`MSECC_LANES-1:0]  par;
    msecc_syn_type            syn;
    logic                     ce;
    logic                     ue;
  } msecc_rd_type;
endpackage : msecc_pkg

// *** msecc_stream_if.sv ***
// Valid/ready stream carrier between the block's own modules.
// Assumes one clock shared by both ends.
`timescale 1ns/100ps
`default_nettype none
interface msecc_stream_if #(parameter int W = 8) ();
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : msecc_stream_if
`default_nettype wire

// *** msecc_chk_gen.sv ***
// XOR trees producing the check byte of a 64-bit data word.
// Assumes a purely combinational use on either path.
`timescale 1ns/100ps
`default_nettype none
`include "msecc_defs.svh"
module msecc_chk_gen (
  input  wire logic [`MSECC_DATA_W-1:0] data_i, // Data word
  output logic      [`MSECC_CHK_W-1:0]  chk_o   // Check byte
);
  localparam logic [`MSECC_DATA_W*`MSECC_CHK_W-1:0] HMAT = `MSECC_HMATRIX;
  // Each check bit covers the data bits whose syndrome has it set
  for (genvar j = 0; j < `MSECC_CHK_W; j++) begin : g_chk
    logic [`MSECC_DATA_W-1:0] sel;
    for (genvar i = 0; i < `MSECC_DATA_W; i++) begin : g_sel
      assign sel[i] = HMAT[i*`MSECC_CHK_W+j];
    end
    assign chk_o[j] = ^(data_i & sel);
  end
endmodule : msecc_chk_gen
`default_nettype wire

// *** msecc_fifo.sv ***
// Flip-flop FIFO with valid/ready on both sides.
// Assumes DEPTH a power of two, at least two.
`timescale 1ns/100ps
`default_nettype none
module msecc_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 4
) (
  input  wire logic   clk_i, // Clock
  input  wire logic   rst_i, // Synchronous reset, high
  msecc_stream_if.snk in_s,  // Filling side
  msecc_stream_if.src out_s  // Draining side
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad
    $error("msecc_fifo: DEPTH must be a power of two >= 2");
  end
  logic [W-1:0]  mem_q [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0]   cnt_q;
  logic          push;
  logic          pop;
  assign in_s.ready  = cnt_q != (AW+1)'(DEPTH);
  assign out_s.valid = cnt_q != '0;
  assign out_s.data  = mem_q[rp_q];
  assign push        = in_s.valid && in_s.ready;
  assign pop         = out_s.valid && out_s.ready;
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wp_q] <= in_s.data;
    end
  end
  // Pointers wrap naturally since DEPTH is a power of two
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wp_q <= wp_q + 1'b1;
      if (pop) rp_q <= rp_q + 1'b1;
      if (push && !pop) cnt_q <= cnt_q + 1'b1;
      else if (pop && !push) cnt_q <= cnt_q - 1'b1;
    end
  end
endmodule : msecc_fifo
`default_nettype wire

// *** msecc_dram_model.sv ***
// Memory channel stand-in: takes write words, stalls at random.
// Assumes the bench pops the captured words from the queue.
`timescale 1ns/100ps
`default_nettype none
module msecc_dram_model (
  input  wire logic        clk_i,   // Clock
  input  wire logic        rst_i,   // Reset, high
  input  wire logic        stall_i, // Allow stalls
  input  wire logic        valid_i, // Word offered
  input  wire logic [71:0] data_i,  // Data and check
  input  wire logic [7:0]  be_i,    // Byte enables
  output logic             ready_o  // Word taken
);
  logic [79:0] words[$];
  // The bench pops this queue, so it is kept out of the always_ff block
  always @(posedge clk_i) begin
    if (!rst_i && valid_i && ready_o) begin
      words.push_back({be_i, data_i});
    end
  end
  // Ready moves just after the edge so the bench sees it settled
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ready_o <= 1'b0;
    end else begin
      ready_o <= !stall_i || ($urandom_range(3) == 0);
    end
  end
endmodule : msecc_dram_model
`default_nettype wire

// *** test_memory_secded_ecc_with_byte_parity.sv ***
// Self-checking bench of the SEC-DED block with byte parity.
// Assumes msecc_top and the memory stand-in model are compiled first.
`timescale 1ns/100ps
`default_nettype none
`include "msecc_defs.svh"
module test_memory_secded_ecc_with_byte_parity;
  import msecc_pkg::*;
  localparam logic [511:0] HM = `MSECC_HMATRIX;
  logic ref_clk_i = 1'b0, sys_rst_i = 1'b1, ecc_en_i = 1'b1;
  logic cnt_clr_i = 1'b0, wr_valid_i = 1'b0, stall = 1'b1;
  logic mem_rd_valid_i = 1'b0, rd_ready_i = 1'b0;
  logic [63:0] wr_data_i = 64'h0;
  logic [7:0]  wr_par_i = 8'h0, wr_be_i = 8'h0;
  logic [71:0] mem_rd_data_i = 72'h0;
  logic        wr_ready_o, mem_wr_valid_o, mem_wr_ready_i, wr_perr_o;
  logic        mem_rd_ready_o, rd_valid_o, rd_ce_o, rd_ue_o;
  logic [71:0] mem_wr_data_o;
  logic [7:0]  mem_wr_be_o, wr_perr_lane_o, rd_par_o, rd_syn_o, err_syn_o;
  logic [63:0] rd_data_o;
  logic [15:0] ce_count_o, ue_count_o;
  logic [81:0] exp_q[$];
  int          err_total = 0, total_checks = 0, ce_exp = 0, ue_exp = 0;

  always #5 ref_clk_i = ~ref_clk_i;

  msecc_top #(.FIFO_DEPTH(4), .CNT_W(16)) u_msecc_top (
    .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .ecc_en_i(ecc_en_i),
    .cnt_clr_i(cnt_clr_i), .wr_valid_i(wr_valid_i), .wr_ready_o(wr_ready_o),
    .wr_data_i(wr_data_i), .wr_par_i(wr_par_i), .wr_be_i(wr_be_i),
    .mem_wr_valid_o(mem_wr_valid_o), .mem_wr_ready_i(mem_wr_ready_i),
    .mem_wr_data_o(mem_wr_data_o), .mem_wr_be_o(mem_wr_be_o),
    .wr_perr_o(wr_perr_o), .wr_perr_lane_o(wr_perr_lane_o),
    .mem_rd_valid_i(mem_rd_valid_i), .mem_rd_ready_o(mem_rd_ready_o),
    .mem_rd_data_i(mem_rd_data_i), .rd_valid_o(rd_valid_o),
    .rd_ready_i(rd_ready_i), .rd_data_o(rd_data_o), .rd_par_o(rd_par_o),
    .rd_syn_o(rd_syn_o), .rd_ce_o(rd_ce_o), .rd_ue_o(rd_ue_o),
    .ce_count_o(ce_count_o), .ue_count_o(ue_count_o), .err_syn_o(err_syn_o));

  msecc_dram_model u_msecc_dram_model (
    .clk_i(ref_clk_i), .rst_i(sys_rst_i), .stall_i(stall),
    .valid_i(mem_wr_valid_o), .data_i(mem_wr_data_o), .be_i(mem_wr_be_o),
    .ready_o(mem_wr_ready_i));

  function automatic logic [7:0] chk(input logic [63:0] d);
    chk = 8'h00;
    for (int i = 0; i < 64; i++) if (d[i]) chk ^= HM[i*8 +: 8];
  endfunction : chk

  function automatic logic [7:0] par(input logic [63:0] d);
    for (int k = 0; k < 8; k++) par[k] = ^d[k*8 +: 8];
  endfunction : par

  // Expected read result as {ue, ce, syndrome, parity, data}
  function automatic logic [81:0] dec(input logic [71:0] w);
    logic [7:0]  s;
    logic [63:0] d;
    logic        ce;
    logic        ue;
    d = w[63:0];
    s = ecc_en_i ? chk(d) ^ w[71:64] : 8'h00;
    ce = 1'b0;
    ue = (s != 8'h00);
    if ($countones(s) == 1) ce = 1'b1;
    for (int i = 0; i < 64; i++) if (s != 8'h00 && HM[i*8 +: 8] == s) begin
      d[i] = !d[i];
      ce = 1'b1;
    end
    ue = ue && !ce;
    dec = {ue, ce, s, par(d) ^ {8{ue}}, d};
  endfunction : dec

  task automatic cmp(input logic [81:0] got, input logic [81:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  task automatic wr(input logic [63:0] d, input logic [7:0] bad,
                    output logic [71:0] w);
    logic [79:0] q;
    logic [7:0]  c;
    logic [9:0]  g;
    int          n;
    @(negedge ref_clk_i);
    wr_valid_i = 1'b1;
    wr_data_i = d;
    wr_par_i = par(d) ^ bad;
    wr_be_i = 8'($urandom);
    n = 0;
    while (wr_ready_o !== 1'b1 && n < 50) begin
      @(negedge ref_clk_i);
      n++;
    end
    @(negedge ref_clk_i);
    wr_valid_i = 1'b0;
    wr_data_i = ~d;
    g = {mem_wr_valid_o, wr_perr_o, wr_perr_lane_o};
    cmp(g, {1'b1, |bad, bad});
    while (u_msecc_dram_model.words.size() == 0 && n < 100) begin
      @(negedge ref_clk_i);
      n++;
    end
    q = u_msecc_dram_model.words.pop_front();
    c = ecc_en_i ? chk(d) ^ ((|bad) ? 8'h67 : 8'h00) : 8'h00;
    cmp(q, {wr_be_i, c, d});
    w = q[71:0];
  endtask : wr

  task automatic push(input logic [71:0] w);
    logic [81:0] e;
    int          n;
    @(negedge ref_clk_i);
    mem_rd_valid_i = 1'b1;
    mem_rd_data_i = w;
    n = 0;
    while (mem_rd_ready_o !== 1'b1 && n < 50) begin
      @(negedge ref_clk_i);
      n++;
    end
    e = dec(w);
    @(negedge ref_clk_i);
    mem_rd_valid_i = 1'b0;
    mem_rd_data_i = ~w;
    exp_q.push_back(e);
    ce_exp += e[80];
    ue_exp += e[81];
    if (e[81] || e[80]) cmp(err_syn_o, e[79:72]);
  endtask : push

  task automatic pop();
    logic [81:0] e;
    logic [81:0] g;
    int          n;
    e = exp_q.pop_front();
    n = 0;
    // Let an edge pass so ready never drops and rises in one step
    @(negedge ref_clk_i);
    while (rd_valid_o !== 1'b1 && n < 50) begin
      @(negedge ref_clk_i);
      n++;
    end
    g = {rd_ue_o, rd_ce_o, rd_syn_o, rd_par_o, rd_data_o};
    cmp(g, e);
    rd_ready_i = 1'b1;
    @(negedge ref_clk_i);
    rd_ready_i = 1'b0;
  endtask : pop

  task automatic end_sim();
    $display("checks=%0d errors=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_sim

  initial begin
    #400000;
    err_total++;
    $display("ERROR t=%0t watchdog got=%h exp=%h", $time, 1'b0, 1'b1);
    end_sim();
  end

  initial begin
    logic [71:0] w;
    logic [71:0] m;
    logic [7:0]  bad;
    int          b1;
    int          c5;
    b1 = $urandom(32'hf223dbb8);
    repeat (16) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    sys_rst_i = 1'b0;
    cmp({mem_wr_valid_o, wr_perr_o, rd_valid_o, rd_ce_o, rd_ue_o, wr_ready_o,
         mem_rd_ready_o, ce_count_o, ue_count_o, err_syn_o},
        47'h300_0000_0000);
    cmp({HM[7:0], HM[511:504]}, 16'h234c);
    // The parity-error code is the ninth five-hot code
    c5 = int'($countones(`MSECC_SYN_PARERR) == 5);
    for (int i = 0; i < 64; i++) begin
      cmp($countones(HM[i*8 +: 8]) % 2, 1);
      c5 += ($countones(HM[i*8 +: 8]) == 5);
    end
    cmp(c5, 9);
    $display("test reset done");
    // Random words, some written with bad lanes, read back with zero, one or two flips
    for (int t = 0; t < 24; t++) begin
      bad = (t % 4 == 0) ? 8'h01 << $urandom_range(7) : 8'h00;
      if (t == 8) bad = 8'hff;
      wr({$urandom, $urandom}, bad, w);
      b1 = $urandom_range(71);
      m = (t % 3 == 0) ? 72'h0 : 72'h1 << b1;
      if (t % 3 == 2) m |= 72'h1 << ((b1 + 1 + $urandom_range(70)) % 72);
      push(w ^ m);
      pop();
    end
    $display("test random done");
    for (int b = 0; b < 72; b++) begin
      w[63:0] = {$urandom, $urandom};
      w[71:64] = chk(w[63:0]);
      push(w ^ (72'h1 << b));
      pop();
    end
    $display("test single done");
    // Fill the buffer while the reader stalls, then drain in order
    for (int k = 0; k < 4; k++) push(72'({$urandom, $urandom, $urandom}));
    cmp(mem_rd_ready_o, 1'b0);
    for (int k = 0; k < 4; k++) pop();
    cmp({rd_valid_o, rd_ce_o, rd_ue_o}, 3'b000);
    $display("test fifo done");
    ecc_en_i = 1'b0;
    stall = 1'b0;
    wr({$urandom, $urandom}, 8'h00, w);
    push(w ^ 72'h3);
    pop();
    @(negedge ref_clk_i);
    ecc_en_i = 1'b1;
    $display("test bypass done");
    cmp({ce_count_o, ue_count_o}, {ce_exp[15:0], ue_exp[15:0]});
    cnt_clr_i = 1'b1;
    @(negedge ref_clk_i);
    cmp({ce_count_o, ue_count_o}, 32'h0);
    // A correctable word taken while clearing still counts as one
    w[63:0] = {$urandom, $urandom};
    w[71:64] = chk(w[63:0]);
    push(w ^ 72'h1);
    cnt_clr_i = 1'b0;
    pop();
    cmp({ce_count_o, ue_count_o}, 32'h0001_0000);
    $display("test counters done");
    end_sim();
  end
endmodule : test_memory_secded_ecc_with_byte_parity
`default_nettype wire
